/* rtl/mdv_mul_div_unit.sv */
`timescale 1ns/1ns
module mdv_mul_div_unit (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	// issue from the integer pipeline
	input wire logic op_valid_i,
	input wire mdv_pkg::mdv_op_t op_code_i,
	input wire logic [31:0] first_source_operand_i,
	input wire logic [31:0] second_source_operand_i,
	output logic stall_o,
	// results
	output logic [31:0] upper_result_o,
	output logic [31:0] lower_result_o,
	output logic gpr_valid_o,
	output logic [31:0] gpr_data_o
);

	// ==========================================
	// state
	mdv_pkg::mdv_state_t state_q, state_d;
	mdv_pkg::mdv_op_t op_q, op_d;
	logic [32:0] a_q, a_d;
	logic [16:0] bhi_q, bhi_d;
	logic [63:0] part_q, part_d;
	logic [31:0] hi_q, hi_d, lo_q, lo_d;
	logic stall_q, stall_d;
	logic [5:0] cyc_q, cyc_d, bits_q, bits_d;
	logic [31:0] rem_q, rem_d, quo_q, quo_d, dvs_q, dvs_d;
	logic qneg_q, qneg_d, rneg_q, rneg_d;
	logic pend_q, pend_d, gv_q, gv_d;
	logic [31:0] hold_q, hold_d, gd_q, gd_d;

	// ==========================================
	// datapath
	logic take, sgn, fits, is_div, ext8, ext16, ext24, ge, div_fin, mul_fin;
	logic signed [32:0] ma;
	logic signed [16:0] mb;
	logic signed [49:0] mp;
	logic [63:0] mpx, prod, base, res, div_res;
	logic [32:0] shl, diff;
	logic [31:0] rem_n, quo_n, aa, bb, qq, rr;
	mdv_pkg::mdv_op_t cop;

	always_comb begin
		take = op_valid_i && !stall_q;
		sgn = (op_code_i == mdv_pkg::MDV_OP_MULT) || (op_code_i == mdv_pkg::MDV_OP_MADD)
			|| (op_code_i == mdv_pkg::MDV_OP_MSUB) || (op_code_i == mdv_pkg::MDV_OP_MUL)
			|| (op_code_i == mdv_pkg::MDV_OP_DIV);
		is_div = (op_code_i == mdv_pkg::MDV_OP_DIV) || (op_code_i == mdv_pkg::MDV_OP_DIVU);
		// width of the second operand alone sets the passes
		fits = sgn ? (&second_source_operand_i[31:15] || ~|second_source_operand_i[31:15])
			: ~|second_source_operand_i[31:16];
		ext8 = sgn ? (&first_source_operand_i[31:7] || ~|first_source_operand_i[31:7])
			: ~|first_source_operand_i[31:8];
		ext16 = sgn ? (&first_source_operand_i[31:15] || ~|first_source_operand_i[31:15])
			: ~|first_source_operand_i[31:16];
		ext24 = sgn ? (&first_source_operand_i[31:23] || ~|first_source_operand_i[31:23])
			: ~|first_source_operand_i[31:24];
		// shared 32x16 multiplier
		if (state_q == mdv_pkg::MDV_ST_MUL2) begin
			ma = $signed(a_q);
			mb = $signed(bhi_q);
			cop = op_q;
		end else begin
			ma = $signed({sgn & first_source_operand_i[31], first_source_operand_i});
			mb = $signed({sgn & fits & second_source_operand_i[15],
				second_source_operand_i[15:0]});
			cop = op_code_i;
		end
		mp = ma * mb;
		mpx = {{14{mp[49]}}, mp};
		prod = (state_q == mdv_pkg::MDV_ST_MUL2) ? part_q + {mpx[47:0], 16'h0000} : mpx;
		mul_fin = (state_q == mdv_pkg::MDV_ST_MUL2) || (take && !is_div && fits);
		// one restoring step per clock
		shl = {rem_q, quo_q[31]};
		diff = shl - {1'b0, dvs_q};
		ge = (shl >= {1'b0, dvs_q}) && (bits_q != 6'h00);
		rem_n = (bits_q == 6'h00) ? rem_q : (ge ? diff[31:0] : shl[31:0]);
		quo_n = (bits_q == 6'h00) ? quo_q : {quo_q[30:0], ge};
		qq = qneg_q ? 32'h0 - quo_n : quo_n;
		rr = rneg_q ? 32'h0 - rem_n : rem_n;
		div_res = {rr, qq};
		div_fin = (state_q == mdv_pkg::MDV_ST_DIV) && (cyc_q == 6'h01);
		base = div_fin ? div_res : {hi_q, lo_q};
		case (cop)
			mdv_pkg::MDV_OP_MADD, mdv_pkg::MDV_OP_MADDU: res = base + prod;
			mdv_pkg::MDV_OP_MSUB, mdv_pkg::MDV_OP_MSUBU: res = base - prod;
			default: res = prod;
		endcase
		aa = (sgn && first_source_operand_i[31]) ? 32'h0 - first_source_operand_i
			: first_source_operand_i;
		bb = (sgn && second_source_operand_i[31]) ? 32'h0 - second_source_operand_i
			: second_source_operand_i;
	end

	// ==========================================
	// control and registers next state
	always_comb begin
		state_d = state_q;
		op_d = op_q;
		a_d = a_q;
		bhi_d = bhi_q;
		part_d = part_q;
		hi_d = hi_q;
		lo_d = lo_q;
		cyc_d = cyc_q;
		bits_d = bits_q;
		rem_d = rem_q;
		quo_d = quo_q;
		dvs_d = dvs_q;
		qneg_d = qneg_q;
		rneg_d = rneg_q;
		hold_d = hold_q;
		pend_d = 1'b0;
		gv_d = pend_q;
		gd_d = pend_q ? hold_q : gd_q;
		// divide keeps running whatever the integer pipeline does
		if (state_q == mdv_pkg::MDV_ST_DIV) begin
			rem_d = rem_n;
			quo_d = quo_n;
			bits_d = (bits_q == 6'h00) ? 6'h00 : bits_q - 6'h01;
			cyc_d = cyc_q - 6'h01;
			if (div_fin) begin
				hi_d = div_res[63:32];
				lo_d = div_res[31:0];
				state_d = mdv_pkg::MDV_ST_IDLE;
			end
		end
		if (state_q == mdv_pkg::MDV_ST_MUL2) begin
			state_d = mdv_pkg::MDV_ST_IDLE;
		end
		if (mul_fin) begin
			if (cop == mdv_pkg::MDV_OP_MUL) begin
				hold_d = prod[31:0];
				pend_d = 1'b1;
			end else begin
				hi_d = res[63:32];
				lo_d = res[31:0];
			end
		end
		if (take && !is_div) begin
			op_d = op_code_i;
			if (!fits) begin
				// first pass on the low half, second pass on the high half
				a_d = {sgn & first_source_operand_i[31], first_source_operand_i};
				bhi_d = {sgn & second_source_operand_i[31], second_source_operand_i[31:16]};
				part_d = prod;
				state_d = mdv_pkg::MDV_ST_MUL2;
			end
		end
		if (take && is_div) begin
			state_d = mdv_pkg::MDV_ST_DIV;
			qneg_d = sgn && (first_source_operand_i[31] ^ second_source_operand_i[31]);
			rneg_d = sgn && first_source_operand_i[31];
			dvs_d = bb;
			rem_d = 32'h0;
			if (ext8) begin
				quo_d = aa << mdv_pkg::MDV_SKIP_8;
				bits_d = mdv_pkg::MDV_DIV_BITS - mdv_pkg::MDV_SKIP_8;
				cyc_d = mdv_pkg::MDV_LAT_8 - 6'h01;
			end else if (ext16) begin
				quo_d = aa << mdv_pkg::MDV_SKIP_16;
				bits_d = mdv_pkg::MDV_DIV_BITS - mdv_pkg::MDV_SKIP_16;
				cyc_d = mdv_pkg::MDV_LAT_16 - 6'h01;
			end else if (ext24) begin
				quo_d = aa << mdv_pkg::MDV_SKIP_24;
				bits_d = mdv_pkg::MDV_DIV_BITS - mdv_pkg::MDV_SKIP_24;
				cyc_d = mdv_pkg::MDV_LAT_24 - 6'h01;
			end else begin
				quo_d = aa;
				bits_d = mdv_pkg::MDV_DIV_BITS;
				cyc_d = mdv_pkg::MDV_LAT_32 - 6'h01;
			end
		end
		// interlock: second pass, or divide until its last cycle
		stall_d = (state_d == mdv_pkg::MDV_ST_MUL2)
			|| ((state_d == mdv_pkg::MDV_ST_DIV) && (cyc_d != 6'h01));
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			state_q <= mdv_pkg::MDV_ST_IDLE;
			op_q <= mdv_pkg::MDV_OP_MULT;
			a_q <= 33'h0;
			bhi_q <= 17'h0;
			part_q <= 64'h0;
			hi_q <= 32'h0;
			lo_q <= 32'h0;
			stall_q <= 1'b0;
			cyc_q <= 6'h00;
			bits_q <= 6'h00;
			rem_q <= 32'h0;
			quo_q <= 32'h0;
			dvs_q <= 32'h0;
			qneg_q <= 1'b0;
			rneg_q <= 1'b0;
			pend_q <= 1'b0;
			gv_q <= 1'b0;
			hold_q <= 32'h0;
			gd_q <= 32'h0;
		end else begin
			state_q <= state_d;
			op_q <= op_d;
			a_q <= a_d;
			bhi_q <= bhi_d;
			part_q <= part_d;
			hi_q <= hi_d;
			lo_q <= lo_d;
			stall_q <= stall_d;
			cyc_q <= cyc_d;
			bits_q <= bits_d;
			rem_q <= rem_d;
			quo_q <= quo_d;
			dvs_q <= dvs_d;
			qneg_q <= qneg_d;
			rneg_q <= rneg_d;
			pend_q <= pend_d;
			gv_q <= gv_d;
			hold_q <= hold_d;
			gd_q <= gd_d;
		end
	end

	assign stall_o = stall_q;
	assign upper_result_o = hi_q;
	assign lower_result_o = lo_q;
	assign gpr_valid_o = gv_q;
	assign gpr_data_o = gd_q;

	// ==========================================
	// checks
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rstn_i);

	logic [63:0] exp_s, exp_u;
	logic [31:0] exp_q;
	always_comb begin
		exp_s = 64'($signed(first_source_operand_i)) * 64'($signed(second_source_operand_i));
		exp_u = {32'h0, first_source_operand_i} * {32'h0, second_source_operand_i};
		exp_q = (second_source_operand_i == 32'h0) ? 32'h0
			: first_source_operand_i / second_source_operand_i;
	end

	sequence s_take(mdv_pkg::mdv_op_t o);
		take && op_code_i == o;
	endsequence
	sequence s_div8_busy;
		stall_o [*8] ##1 stall_o ##1 stall_o ##1 !stall_o;
	endsequence

	property p_mul16_lat;
		s_take(mdv_pkg::MDV_OP_MULT) and fits |=> {upper_result_o, lower_result_o} == $past(exp_s);
	endproperty
	a_mul16_lat: assert property (p_mul16_lat) else $error("16-bit mult result late");
	property p_mul32_lat;
		s_take(mdv_pkg::MDV_OP_MULTU) and !fits
			|-> ##2 {upper_result_o, lower_result_o} == $past(exp_u, 2);
	endproperty
	a_mul32_lat: assert property (p_mul32_lat) else $error("32-bit multu result wrong");
	property p_mul32_rate;
		take && !is_div && !fits |=> stall_o ##1 !stall_o;
	endproperty
	a_mul32_rate: assert property (p_mul32_rate) else $error("full multiply repeat not 2");
	property p_mul16_rate;
		take && !is_div && fits |=> !stall_o;
	endproperty
	a_mul16_rate: assert property (p_mul16_rate) else $error("16-bit multiply stalled");
	property p_gpr16;
		s_take(mdv_pkg::MDV_OP_MUL) and fits
			|-> ##2 gpr_valid_o && gpr_data_o == $past(exp_s[31:0], 2);
	endproperty
	a_gpr16: assert property (p_gpr16) else $error("general register latency not 2");
	property p_gpr32;
		s_take(mdv_pkg::MDV_OP_MUL) and !fits |-> ##3 gpr_valid_o && gpr_data_o == $past(exp_s[31:0], 3);
	endproperty
	a_gpr32: assert property (p_gpr32) else $error("general register latency not 3");
	property p_div8_rate;
		s_take(mdv_pkg::MDV_OP_DIVU) and ext8 |=> s_div8_busy;
	endproperty
	a_div8_rate: assert property (p_div8_rate) else $error("8-bit divide repeat not 11");
	property p_div8_res;
		s_take(mdv_pkg::MDV_OP_DIVU) and ext8 |-> ##11 div_fin ##1
			(lower_result_o == $past(exp_q, 12) || $past(take && !is_div));
	endproperty
	a_div8_res: assert property (p_div8_res) else $error("8-bit divide quotient wrong");
	property p_div32_rate;
		s_take(mdv_pkg::MDV_OP_DIVU) and !ext24 |-> ##31 stall_o ##1 !stall_o;
	endproperty
	a_div32_rate: assert property (p_div32_rate) else $error("32-bit divide repeat not 32");
	property p_div_hold;
		state_q == mdv_pkg::MDV_ST_DIV && cyc_q > 6'h01 |-> stall_o;
	endproperty
	a_div_hold: assert property (p_div_hold) else $error("issue open during divide");

endmodule : mdv_mul_div_unit

/* rtl/mdv_pkg.sv */
package mdv_pkg;

	// ==========================================
	// operations and states
	typedef enum logic [3:0] {
		MDV_OP_MULT = 4'h0,
		MDV_OP_MULTU = 4'h1,
		MDV_OP_MADD = 4'h2,
		MDV_OP_MADDU = 4'h3,
		MDV_OP_MSUB = 4'h4,
		MDV_OP_MSUBU = 4'h5,
		MDV_OP_MUL = 4'h6,
		MDV_OP_DIV = 4'h7,
		MDV_OP_DIVU = 4'h8
	} mdv_op_t;

	typedef enum logic [1:0] {
		MDV_ST_IDLE = 2'h0,
		MDV_ST_MUL2 = 2'h1,
		MDV_ST_DIV = 2'h3
	} mdv_state_t;

	// ==========================================
	// multiplier geometry
	localparam int MDV_PASS_W = 16;

	// ==========================================
	// divide early-in skips and latencies
	localparam logic [5:0] MDV_DIV_BITS = 6'h20;
	localparam logic [5:0] MDV_SKIP_8 = 6'h17;
	localparam logic [5:0] MDV_SKIP_16 = 6'h0F;
	localparam logic [5:0] MDV_SKIP_24 = 6'h07;
	localparam logic [5:0] MDV_LAT_8 = 6'h0C;
	localparam logic [5:0] MDV_LAT_16 = 6'h13;
	localparam logic [5:0] MDV_LAT_24 = 6'h1A;
	localparam logic [5:0] MDV_LAT_32 = 6'h21;

endpackage : mdv_pkg

/* tb/mdv_issue_model.sv */
`timescale 1ns/1ns
// ==========================================
// issuing pipeline model
module mdv_issue_model (
	// clock and stall
	input wire logic sys_clk_i,
	input wire logic stall_i,
	// operation to the unit
	output logic op_valid_o,
	output mdv_pkg::mdv_op_t op_code_o,
	output logic [31:0] first_o,
	output logic [31:0] second_o
);
	initial begin
		op_valid_o = 1'b0;
		op_code_o = mdv_pkg::MDV_OP_MULT;
		first_o = 32'h0;
		second_o = 32'h0;
	end
	// present, hold until an edge sees no stall; n counts edges
	task automatic issue(input mdv_pkg::mdv_op_t op, input logic [31:0] a, b, output int n);
		op_valid_o = 1'b1;
		op_code_o = op;
		first_o = a;
		second_o = b;
		n = 0;
		do begin
			@(posedge sys_clk_i);
			n++;
		end while (stall_i !== 1'b0 && n < 64);
		#1;
	endtask : issue
	// released operands never keep their last value
	task automatic idle;
		op_valid_o = 1'b0;
		first_o = ~first_o;
		second_o = ~second_o;
	endtask : idle
endmodule : mdv_issue_model

/* tb/tb_top.sv */
`timescale 1ns/1ns
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin failures++; \
	$display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
// ==========================================
// bench top
module tb_top;
	logic sys_clk, rstn, op_valid, stall, gv;
	mdv_pkg::mdv_op_t op_code;
	logic [31:0] a, b, up, lo, gd;
	logic [63:0] acc = 64'h0;
	int failures = 0;
	int checks = 0;
	int cyc = 0;
	logic [31:0] dv [4] = '{32'h64, 32'h7000, 32'h0070_0000, 32'h7000_0000};
	int lat [4] = '{12, 19, 26, 33};
	mdv_mul_div_unit DUT (.sys_clk_i(sys_clk), .rstn_i(rstn), .op_valid_i(op_valid),
		.op_code_i(op_code), .first_source_operand_i(a), .second_source_operand_i(b),
		.stall_o(stall), .upper_result_o(up), .lower_result_o(lo), .gpr_valid_o(gv),
		.gpr_data_o(gd));
	mdv_issue_model PM (.sys_clk_i(sys_clk), .stall_i(stall), .op_valid_o(op_valid),
		.op_code_o(op_code), .first_o(a), .second_o(b));
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	task automatic tick;
		@(posedge sys_clk);
		#1;
	endtask : tick
	task automatic conclude;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : conclude
	// pair-writing multiply, expected value kept in acc
	task automatic mop(input mdv_pkg::mdv_op_t op, input logic [31:0] x, y, input int l);
		logic [63:0] p, old;
		int n;
		old = acc;
		if (op inside {mdv_pkg::MDV_OP_MULTU, mdv_pkg::MDV_OP_MADDU, mdv_pkg::MDV_OP_MSUBU})
			p = {32'h0, x} * {32'h0, y};
		else
			p = {{32{x[31]}}, x} * {{32{y[31]}}, y};
		if (op inside {mdv_pkg::MDV_OP_MADD, mdv_pkg::MDV_OP_MADDU}) acc = acc + p;
		else if (op inside {mdv_pkg::MDV_OP_MSUB, mdv_pkg::MDV_OP_MSUBU}) acc = acc - p;
		else acc = p;
		PM.issue(op, x, y, n);
		`CHK(n, 1)
		if (l > 1) begin
			PM.idle;
			`CHK({up, lo}, old)
			tick;
		end
		`CHK({up, lo}, acc)
	endtask : mop
	// general-register multiply
	task automatic mulg(input logic [31:0] x, y, input int l);
		logic [63:0] p;
		int n;
		p = {{32{x[31]}}, x} * {{32{y[31]}}, y};
		PM.issue(mdv_pkg::MDV_OP_MUL, x, y, n);
		PM.idle;
		repeat (l - 2) tick;
		`CHK(gv, 1'b0)
		tick;
		`CHK(gv, 1'b1)
		`CHK(gd, p[31:0])
		`CHK({up, lo}, acc)
	endtask : mulg
	// divide; chk issues a multiply at once to measure the repeat
	task automatic div(input mdv_pkg::mdv_op_t op, input logic [31:0] x, input int l, chk);
		logic [31:0] q, r;
		int n;
		if (op == mdv_pkg::MDV_OP_DIVU) begin
			q = x / 32'h7;
			r = x % 32'h7;
		end else begin
			q = $signed(x) / $signed(32'h7);
			r = $signed(x) % $signed(32'h7);
		end
		PM.issue(op, x, 32'h7, n);
		if (chk) begin
			PM.issue(mdv_pkg::MDV_OP_MULT, 32'h2, 32'h3, n);
			`CHK(n, l - 1)
			acc = 64'h6;
			`CHK({up, lo}, acc)
		end else begin
			PM.idle;
			repeat (l - 2) tick;
			`CHK({up, lo}, acc)
			tick;
			acc = {r, q};
			`CHK({up, lo}, acc)
		end
		PM.idle;
		tick;
	endtask : div
	// back-to-back full multiplies
	task automatic b2b;
		int n;
		PM.issue(mdv_pkg::MDV_OP_MULTU, 32'h3, 32'h0002_0000, n);
		PM.issue(mdv_pkg::MDV_OP_MULTU, 32'h5, 32'h0003_0000, n);
		`CHK(n, 2)
		PM.idle;
		tick;
		acc = 64'h0000_0000_000F_0000;
		`CHK({up, lo}, acc)
	endtask : b2b
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 3000) begin
			failures++;
			conclude;
		end
	end
	initial begin
		rstn = 1'b0;
		repeat (6) @(posedge sys_clk);
		#1;
		`CHK({stall, gv, up, lo}, 66'h0)
		rstn = 1'b1;
		tick;
		mop(mdv_pkg::MDV_OP_MULT, 32'h8000_0001, 32'hFFFF_8000, 1);
		mop(mdv_pkg::MDV_OP_MADD, 32'h1234_5678, 32'h0000_7FFF, 1);
		mop(mdv_pkg::MDV_OP_MSUBU, 32'hFFFF_FFFF, 32'h0000_FFFF, 1);
		mop(mdv_pkg::MDV_OP_MULTU, 32'hFFFF_FFFF, 32'h0000_FFFF, 1);
		mop(mdv_pkg::MDV_OP_MADDU, 32'h3, 32'h5, 1);
		mop(mdv_pkg::MDV_OP_MSUB, 32'h7FFF_FFFF, 32'hFFFF_FFFE, 1);
		mop(mdv_pkg::MDV_OP_MULT, 32'h5, 32'h0001_0000, 2);
		mop(mdv_pkg::MDV_OP_MADDU, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 2);
		mop(mdv_pkg::MDV_OP_MSUB, 32'h7, 32'h8000_0000, 2);
		b2b;
		mulg(32'h8000_0000, 32'h0000_7FFF, 2);
		mulg(32'h0001_0001, 32'h0001_0001, 3);
		for (int i = 0; i < 4; i++) begin
			div(mdv_pkg::MDV_OP_DIV, -dv[i], lat[i], 0);
			div(mdv_pkg::MDV_OP_DIVU, dv[i], lat[i], 0);
			div(mdv_pkg::MDV_OP_DIVU, dv[i], lat[i], 1);
		end
		conclude;
	end
endmodule : tb_top
